// File: aqr_sensor_end.sv
// sensor end: burn-in, pwm, serial reports, i2c slave
`timescale 1ns/1ps
module aqr_fifo #(
  parameter int W = 8,
  parameter int D = aqr_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import aqr_pkg::*;
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("aqr_fifo: depth must be a power of two");
  end
  logic [W-1:0] mem [D];
  logic [AW:0] wr;
  logic [AW:0] rd;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wr - rd) != (AW + 1)'(D);
  assign out_valid = wr != rd;
  assign out_data = mem[rd[AW-1:0]];
  always_ff @(posedge clk) begin
    if (reset) begin
      wr <= '0;
      rd <= '0;
    end else begin
      if (push) wr <= wr + 1'b1;
      if (pop) rd <= rd + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem[wr[AW-1:0]] <= in_data;
  end
endmodule

// How it works
// RULE1 - answer only address 90 with read bit
// RULE2 - slave keeps pace with 100 kHz clock
// RULE3 - single master, no arbitration logic
// RULE4 - master starts with START and read address
// RULE5 - after ack, send high byte msb first
// RULE6 - master acks high byte, low byte follows
// RULE7 - master nacks low byte, stops, line released
// RULE8 - 16-bit value, high byte then low byte
// RULE9 - 6.5 kHz pwm, 350..2000 ppm to 0..100%
// RULE10 - serial 9600 baud, 8 data, no parity, 1 stop
// RULE11 - seven header lines before any report
// RULE12 - one report line each second
// RULE13 - report: ppm column, then resistance column
// RULE14 - burn-in forces 350 ppm and 50% pwm
// RULE15 - burn-in completion written to non-volatile flag
// RULE16 - recorded burn-in gives 15 minute run-in
// RULE17 - clamp pwm duty outside the ppm range
// RULE18 - foreign address: no ack, ignore until START
module aqr_sensor_end #(
  parameter int SEC_CYC = aqr_pkg::SEC_CYC,
  parameter int PWM_CYC = aqr_pkg::PWM_CYC,
  parameter int BAUD_CYC = aqr_pkg::BAUD_CYC
) (
  // system clock domain
  input wire logic clk,
  input wire logic reset,
  // link clock domain
  input wire logic link_clk,
  input wire logic link_reset,
  // measurement from the sensing core
  input wire logic [15:0] meas_ppm,
  input wire logic [aqr_pkg::RES_W-1:0] meas_res,
  input wire logic meas_valid,
  // non-volatile burn-in flag
  input wire logic nv_burned,
  output logic nv_set_burned,
  // readout outputs
  output logic burn_active,
  output logic pwm_out,
  output logic uart_tx,
  // i2c pins
  aqr_link_if.dev link
);
  import aqr_pkg::*;
  localparam int SW = $clog2(SEC_CYC);
  localparam int PW = $clog2(PWM_CYC + 1);
  localparam int BW = $clog2(BAUD_CYC);
  if (SEC_CYC < 4 || PWM_CYC < 4 || BAUD_CYC < 4) begin : g_chk
    $error("aqr_sensor_end: cycle counts too small");
  end

  function automatic logic [RES_W-1:0] pow10(input logic [2:0] i);
    case (i)
      3'h0: pow10 = 24'h000001;
      3'h1: pow10 = 24'h00000A;
      3'h2: pow10 = 24'h000064;
      3'h3: pow10 = 24'h0003E8;
      3'h4: pow10 = 24'h002710;
      3'h5: pow10 = 24'h0186A0;
      3'h6: pow10 = 24'h0F4240;
      default: pow10 = 24'h989680;
    endcase
  endfunction

  // strap from storage, caught once after reset release
  logic nv_s1;
  logic nv_s2;
  logic nv_known;
  logic nv_prior;
  logic [1:0] boot_cnt;
  always_ff @(posedge clk) begin
    nv_s1 <= nv_burned;
    nv_s2 <= nv_s1;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      boot_cnt <= '0;
      nv_known <= 1'b0;
      nv_prior <= 1'b0;
    end else if (!nv_known) begin
      boot_cnt <= boot_cnt + 1'b1;
      nv_known <= boot_cnt == BOOT_LAST;
      nv_prior <= nv_s2;
    end
  end

  // warm-up timing in whole seconds
  logic [SW-1:0] sec_cnt;
  logic [15:0] warm_sec;
  wire sec_tick = sec_cnt == SW'(SEC_CYC - 1);
  wire [15:0] warm_lim = nv_prior ? 16'(RUN_IN_S) : 16'(BURN_IN_S);
  always_ff @(posedge clk) begin
    if (reset) begin
      sec_cnt <= '0;
      warm_sec <= '0;
      burn_active <= 1'b1;
      nv_set_burned <= 1'b0;
    end else begin
      sec_cnt <= sec_tick ? '0 : sec_cnt + 1'b1;
      nv_set_burned <= 1'b0;
      if (nv_known && burn_active && sec_tick) begin
        warm_sec <= warm_sec + 16'h0001;
        if (warm_sec == warm_lim - 16'h0001) begin // [RULE16]
          burn_active <= 1'b0;
          nv_set_burned <= !nv_prior; // [RULE15]
        end
      end
    end
  end

  // latest prediction, held until the core updates it
  logic [15:0] pred;
  logic [RES_W-1:0] res;
  always_ff @(posedge clk) begin
    if (reset) begin
      pred <= 16'(PPM_LO);
      res <= '0;
    end else if (meas_valid) begin
      pred <= meas_ppm;
      res <= meas_res;
    end
  end
  wire [15:0] eff_ppm = burn_active ? 16'(PPM_LO) : pred; // [RULE14]

  // pwm; duty only changes at the period boundary to avoid glitches
  logic [PW-1:0] pwm_cnt;
  logic [PW-1:0] duty;
  wire [15:0] span = pred - 16'(PPM_LO);
  wire [31:0] scaled = 32'(span) * 32'(PWM_CYC) / 32'(PPM_HI - PPM_LO);
  wire [PW-1:0] next_duty = burn_active ? PW'(PWM_CYC / 2) : // [RULE14]
    (pred <= 16'(PPM_LO)) ? '0 : // [RULE17]
    (pred >= 16'(PPM_HI)) ? PW'(PWM_CYC) : PW'(scaled); // [RULE9]
  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_cnt <= '0;
      duty <= '0;
      pwm_out <= 1'b0;
    end else begin
      if (pwm_cnt == PW'(PWM_CYC - 1)) begin // [RULE9]
        pwm_cnt <= '0;
        duty <= next_duty;
      end else begin
        pwm_cnt <= pwm_cnt + 1'b1;
      end
      pwm_out <= pwm_cnt < duty;
    end
  end

  // report text generator feeding the fifo
  aqr_gen_t gst;
  logic [2:0] hdr_cnt;
  logic hdr_done;
  logic [RES_W-1:0] val;
  logic [2:0] pidx;
  logic [3:0] dig;
  logic col;
  logic [7:0] ch;
  logic f_ready;
  logic f_valid;
  logic [7:0] f_data;
  wire [RES_W-1:0] pw = pow10(pidx);
  wire sub = gst == G_NUM && val >= pw;
  wire emit = gst != G_IDLE && !sub;
  wire took = emit && f_ready;
  always_comb begin
    case (gst)
      G_HEAD: ch = CH_H;
      G_HNUM: ch = CH_0 + {5'h00, hdr_cnt};
      G_NUM: ch = CH_0 + {4'h0, dig};
      G_TAB: ch = CH_TAB;
      G_CR: ch = CH_CR;
      default: ch = CH_LF;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      gst <= G_HEAD; // [RULE11]
      hdr_cnt <= '0;
      hdr_done <= 1'b0;
      val <= '0;
      pidx <= '0;
      dig <= '0;
      col <= 1'b0;
    end else if (sub) begin
      val <= val - pw;
      dig <= dig + 4'h1;
    end else if (gst == G_IDLE) begin
      // a tick during a running line is skipped; a line is far under 1 s
      if (hdr_done && sec_tick) begin // [RULE12]
        gst <= G_NUM;
        val <= RES_W'(eff_ppm); // [RULE13]
        pidx <= PPM_TOP;
        dig <= '0;
        col <= 1'b0;
      end
    end else if (took) begin
      case (gst)
        G_HEAD: gst <= G_HNUM;
        G_HNUM: gst <= G_CR;
        G_NUM: begin
          dig <= '0;
          if (pidx != 3'h0) pidx <= pidx - 3'h1;
          else gst <= col ? G_CR : G_TAB;
        end
        G_TAB: begin
          gst <= G_NUM;
          col <= 1'b1;
          val <= res; // [RULE13]
          pidx <= RES_TOP;
        end
        G_CR: gst <= G_LF;
        G_LF: begin
          if (!hdr_done && hdr_cnt != HDR_LAST) begin // [RULE11]
            hdr_cnt <= hdr_cnt + 3'h1;
            gst <= G_HEAD;
          end else begin
            hdr_done <= 1'b1;
            gst <= G_IDLE;
          end
        end
        default: gst <= G_IDLE;
      endcase
    end
  end

  wire logic tx_idle;
  aqr_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(emit),
    .in_ready(f_ready),
    .in_data(ch),
    .out_valid(f_valid),
    .out_ready(tx_idle),
    .out_data(f_data)
  );

  // 8N1 transmitter, lsb first
  logic [9:0] tx_sh;
  logic [3:0] tx_bits;
  logic [BW-1:0] baud_cnt;
  assign tx_idle = tx_bits == 4'h0;
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_sh <= 10'h3FF;
      tx_bits <= '0;
      baud_cnt <= '0;
      uart_tx <= 1'b1;
    end else begin
      if (tx_idle) begin
        if (f_valid) begin
          tx_sh <= {1'b1, f_data, 1'b0}; // [RULE10]
          tx_bits <= FRAME_BITS;
          baud_cnt <= '0;
        end
      end else if (baud_cnt == BW'(BAUD_CYC - 1)) begin // [RULE10]
        baud_cnt <= '0;
        tx_sh <= {1'b1, tx_sh[9:1]};
        tx_bits <= tx_bits - 4'h1;
      end else begin
        baud_cnt <= baud_cnt + 1'b1;
      end
      uart_tx <= tx_idle ? 1'b1 : tx_sh[0];
    end
  end

  // value handed to the link domain by a req/ack toggle pair
  logic [15:0] xd;
  logic x_req;
  logic x_ack_s1;
  logic x_ack_s2;
  logic r_s1;
  logic r_s2;
  logic l_ack;
  logic [15:0] l_val;
  always_ff @(posedge clk) begin
    if (reset) begin
      xd <= 16'(PPM_LO);
      x_req <= 1'b0;
      x_ack_s1 <= 1'b0;
      x_ack_s2 <= 1'b0;
    end else begin
      x_ack_s1 <= l_ack;
      x_ack_s2 <= x_ack_s1;
      if (x_req == x_ack_s2) begin
        xd <= eff_ppm;
        x_req <= !x_req;
      end
    end
  end
  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      r_s1 <= 1'b0;
      r_s2 <= 1'b0;
      l_ack <= 1'b0;
      l_val <= 16'(PPM_LO);
    end else begin
      r_s1 <= x_req;
      r_s2 <= r_s1;
      if (r_s2 != l_ack) begin
        l_val <= xd;
        l_ack <= r_s2;
      end
    end
  end

  // i2c slave, oversampling the pins on the link clock
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;
  always_ff @(posedge link_clk) begin
    scl_s1 <= link.scl;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
  end
  wire scl_rise = scl_s2 && !scl_d;
  wire scl_fall = !scl_s2 && scl_d;
  wire start_c = scl_s2 && scl_d && sda_d && !sda_s2;
  wire stop_c = scl_s2 && scl_d && !sda_d && sda_s2;

  // no arbitration: a lone master owns the clock [RULE3]
  aqr_slv_t sst;
  logic [2:0] bcnt;
  logic [7:0] sh;
  logic [15:0] tx_word;
  logic seen;
  logic second;
  always_ff @(posedge link_clk) begin
    if (link_reset) begin
      sst <= S_IDLE;
      bcnt <= '0;
      sh <= '0;
      tx_word <= '0;
      seen <= 1'b0;
      second <= 1'b0;
      link.d_sda_oe <= 1'b0;
      link.d_sda_o <= 1'b0;
    end else if (start_c) begin // [RULE4]
      sst <= S_ADDR;
      bcnt <= '0;
      seen <= 1'b0;
      link.d_sda_oe <= 1'b0;
    end else if (stop_c) begin // [RULE7]
      sst <= S_IDLE;
      link.d_sda_oe <= 1'b0;
    end else begin
      case (sst)
        S_ADDR: begin
          if (scl_rise) begin // [RULE2]
            sh <= {sh[6:0], sda_s2};
            bcnt <= bcnt + 3'h1;
            seen <= bcnt == 3'h7;
          end else if (scl_fall && seen) begin
            seen <= 1'b0;
            if (sh == ADDR_RD) begin // [RULE1]
              sst <= S_AACK;
              link.d_sda_oe <= 1'b1;
              tx_word <= l_val;
            end else begin
              sst <= S_SKIP; // [RULE18]
            end
          end
        end
        S_AACK: if (scl_fall) begin
          sh <= tx_word[15:8]; // [RULE8]
          link.d_sda_oe <= !tx_word[15]; // [RULE5]
          bcnt <= '0;
          second <= 1'b0;
          sst <= S_SEND;
        end
        S_SEND: begin
          if (scl_rise) begin
            bcnt <= bcnt + 3'h1;
          end else if (scl_fall) begin
            if (bcnt == 3'h0) begin
              link.d_sda_oe <= 1'b0;
              sst <= S_MACK;
            end else begin
              sh <= {sh[6:0], 1'b0};
              link.d_sda_oe <= !sh[6]; // [RULE5]
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            if (sda_s2 || second) sst <= S_SKIP; // [RULE7]
            else seen <= 1'b1;
          end else if (scl_fall && seen) begin // [RULE6]
            seen <= 1'b0;
            sh <= tx_word[7:0]; // [RULE8]
            link.d_sda_oe <= !tx_word[7];
            second <= 1'b1;
            sst <= S_SEND;
          end
        end
        S_SKIP: link.d_sda_oe <= 1'b0; // [RULE18]
        default: sst <= S_IDLE;
      endcase
    end
  end
endmodule

// File: aqr_pkg.sv
// shared constants and types for the air quality readout ends
package aqr_pkg;
  localparam int CLK_HZ = 250_000_000;
  // i2c link
  localparam logic [6:0] DEV_ADDR = 7'h5A;
  localparam logic [7:0] ADDR_RD = {DEV_ADDR, 1'b1};
  localparam int I2C_HZ = 100_000;
  localparam int I2C_QTR = CLK_HZ / I2C_HZ / 4;
  localparam logic [4:0] IT_START = 5'h00;
  localparam logic [4:0] IT_ACK = 5'h09;
  localparam logic [4:0] IT_MACK = 5'h12;
  localparam logic [4:0] IT_NACK = 5'h1B;
  localparam logic [4:0] IT_STOP = 5'h1C;
  // pwm
  localparam real PWM_KHZ = 6.5;
  localparam int PWM_CYC = $rtoi(CLK_HZ / (PWM_KHZ * 1000.0));
  localparam int PPM_LO = 350;
  localparam int PPM_HI = 2000;
  // serial reports
  localparam int BAUD = 9600;
  localparam int BAUD_CYC = CLK_HZ / BAUD;
  localparam logic [3:0] FRAME_BITS = 4'hA;
  localparam int REPORT_S = 1;
  localparam int SEC_CYC = CLK_HZ * REPORT_S;
  localparam logic [2:0] HDR_LAST = 3'h6;
  localparam int RES_W = 24;
  localparam logic [2:0] PPM_TOP = 3'h4;
  localparam logic [2:0] RES_TOP = 3'h7;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_TAB = 8'h09;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam int FIFO_DEPTH = 16;
  // warm-up periods, counted in seconds
  localparam int BURN_IN_H = 6;
  localparam int BURN_IN_S = BURN_IN_H * 3600;
  localparam int RUN_IN_MIN = 15;
  localparam int RUN_IN_S = RUN_IN_MIN * 60;
  localparam logic [1:0] BOOT_LAST = 2'h3;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ADDR = 3'b001, S_AACK = 3'b010,
    S_SEND = 3'b011, S_MACK = 3'b100, S_SKIP = 3'b101
  } aqr_slv_t;
  typedef enum logic [2:0] {
    G_IDLE = 3'b000, G_HEAD = 3'b001, G_HNUM = 3'b010, G_NUM = 3'b011,
    G_TAB = 3'b100, G_CR = 3'b101, G_LF = 3'b110
  } aqr_gen_t;
  typedef enum logic {H_IDLE = 1'b0, H_RUN = 1'b1} aqr_host_t;
endpackage

// File: aqr_link_if.sv
// i2c pins shared by the master end and the sensor end
`timescale 1ns/1ps
interface aqr_link_if;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // open-drain wires with pull-ups
  assign scl = !(h_scl_oe && !h_scl_o);
  assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));
  modport host (output h_scl_o, h_scl_oe, h_sda_o, h_sda_oe,
                input scl, sda);
  modport dev (output d_sda_o, d_sda_oe, input scl, sda);
endinterface

// File: aqr_master_end.sv
// master end: reads the 16-bit prediction over i2c
`timescale 1ns/1ps
module aqr_master_end (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // user request and answer
  input wire logic rd_req,
  output logic busy,
  output logic [15:0] result,
  output logic result_valid,
  output logic addr_nack,
  // i2c pins
  aqr_link_if.host link
);
  import aqr_pkg::*;
  localparam int QW = $clog2(I2C_QTR);
  if (I2C_QTR < 4) begin : g_chk
    $error("aqr_master_end: quarter period too short");
  end
  aqr_host_t hst;
  logic [QW-1:0] qcnt;
  logic [1:0] quarter;
  logic [4:0] item;
  logic [15:0] rx;
  logic nack;
  logic scl_s1;
  logic scl_s2;
  logic sda_s1;
  logic sda_s2;
  always_ff @(posedge clk) begin
    scl_s1 <= link.scl;
    scl_s2 <= scl_s1;
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
  end
  // the high phase waits for scl to be seen high
  wire q_run = !(quarter == 2'h2 && !scl_s2);
  wire qtick = q_run && qcnt == QW'(I2C_QTR - 1);
  wire is_start = item == IT_START;
  wire is_stop = item == IT_STOP;
  wire is_addr = item != IT_START && item < IT_ACK;
  wire [2:0] abit = 3'(IT_ACK - 5'h01 - item);
  wire rd_item = item > IT_ACK && item < IT_NACK && item != IT_MACK;
  wire drive_low = is_addr ? !ADDR_RD[abit] : item == IT_MACK; // [RULE6]
  always_ff @(posedge clk) begin
    if (reset) begin
      hst <= H_IDLE;
      busy <= 1'b0;
      qcnt <= '0;
      quarter <= '0;
      item <= '0;
      rx <= '0;
      nack <= 1'b0;
      result <= '0;
      result_valid <= 1'b0;
      addr_nack <= 1'b0;
      link.h_scl_oe <= 1'b0;
      link.h_sda_oe <= 1'b0;
      link.h_scl_o <= 1'b0;
      link.h_sda_o <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (hst == H_IDLE) begin
        if (rd_req) begin
          hst <= H_RUN;
          busy <= 1'b1;
          qcnt <= '0;
          quarter <= '0;
          item <= IT_START;
          nack <= 1'b0;
        end
      end else begin
        qcnt <= qtick ? '0 : (q_run ? qcnt + 1'b1 : qcnt);
        if (qtick) begin
          quarter <= quarter + 2'h1;
          case (quarter)
            2'h0: begin
              link.h_sda_oe <= is_stop || (!is_start && drive_low);
              if (is_start) link.h_scl_oe <= 1'b0;
            end
            2'h1: begin
              if (is_start) link.h_sda_oe <= 1'b1; // [RULE4]
              else link.h_scl_oe <= 1'b0;
            end
            2'h2: begin
              if (is_stop) link.h_sda_oe <= 1'b0; // [RULE7]
              else if (rd_item) rx <= {rx[14:0], sda_s2}; // [RULE8]
              else if (item == IT_ACK && sda_s2) nack <= 1'b1;
            end
            default: begin
              if (is_stop) begin
                hst <= H_IDLE;
                busy <= 1'b0;
                result <= rx;
                result_valid <= !nack;
                addr_nack <= nack;
              end else begin
                link.h_scl_oe <= 1'b1;
                item <= (item == IT_ACK && nack) ? IT_STOP : item + 5'h01;
              end
            end
          endcase
        end
      end
    end
  end
endmodule

// File: aqr_link_checker.sv
// concurrent checks on the i2c wires between the two ends
`timescale 1ns/1ps
module aqr_link_checker (
  // clocks and resets
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic link_reset,
  // wire drivers and levels
  input wire logic h_scl_o,
  input wire logic h_scl_oe,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import aqr_pkg::*;
  // every scl low phase, start and stop included, lasts two quarter periods
  localparam int LO_MIN = 600;
  localparam int LO_MAX = 1900;
  localparam int HI_MIN = 1240;
  logic scl_q;
  logic sda_q;
  logic [3:0] bits;
  logic [1:0] byte_n;
  logic [7:0] shreg;
  logic [15:0] run;
  wire logic scl_rise;
  wire logic start_ev;
  wire logic ack_bit;
  assign scl_rise = scl && !scl_q;
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign ack_bit = scl_rise && bits == 4'h8;
  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  always_ff @(posedge clk) begin
    if (reset || start_ev) begin
      bits <= 4'h0;
      byte_n <= 2'h0;
    end else if (ack_bit) begin
      bits <= 4'h0;
      byte_n <= byte_n + 2'(byte_n != 2'h3);
    end else if (scl_rise) begin
      bits <= bits + 4'h1;
      shreg <= {shreg[6:0], sda};
    end
  end
  // saturating run length of the current scl level
  always_ff @(posedge clk) begin
    if (reset || scl != scl_q) run <= 16'h0000;
    else if (run != 16'hFFFF) run <= run + 16'h0001;
  end
  addr_byte_a: assert property (
    @(posedge clk) disable iff (reset)
    ack_bit && byte_n == 2'h0 |-> shreg == ADDR_RD)
    else $error("first byte is not the read address");
  addr_ack_a: assert property (
    @(posedge clk) disable iff (reset)
    ack_bit && byte_n == 2'h0 && shreg == ADDR_RD |-> !sda && d_sda_oe)
    else $error("own read address not acknowledged");
  addr_quiet_a: assert property (
    @(posedge clk) disable iff (reset)
    byte_n == 2'h0 && bits != 4'h8 |-> !d_sda_oe)
    else $error("sensor drives data during the address");
  // master stays receiver between the first and last bit of each result byte
  host_quiet_a: assert property (
    @(posedge clk) disable iff (reset)
    (byte_n == 2'h1 || byte_n == 2'h2) && bits != 4'h0 && bits != 4'h8
      |-> !h_sda_oe)
    else $error("master drives data during a result byte");
  mack_a: assert property (
    @(posedge clk) disable iff (reset)
    ack_bit && byte_n == 2'h1 |-> !sda && !d_sda_oe)
    else $error("first byte not acknowledged by master");
  nack_a: assert property (
    @(posedge clk) disable iff (reset)
    ack_bit && byte_n == 2'h2 |-> sda && !d_sda_oe)
    else $error("second byte acknowledged or line held");
  stop_release_a: assert property (
    @(posedge clk) disable iff (reset)
    scl && scl_q && !sda_q && sda |=> !d_sda_oe [*8])
    else $error("sensor drives data after stop");
  scl_low_a: assert property (
    @(posedge clk) disable iff (reset)
    scl_rise |-> run >= LO_MIN && run <= LO_MAX)
    else $error("scl low phase out of range");
  scl_high_a: assert property (
    @(posedge clk) disable iff (reset)
    !scl && scl_q |-> run >= HI_MIN)
    else $error("scl high phase too short");
  oe_change_a: assert property (
    @(posedge link_clk) disable iff (link_reset)
    $changed(d_sda_oe) |-> !scl)
    else $error("sensor changes data while scl high");
endmodule

// File: air_quality_readout_ports_tb_top.sv
// self-checking bench joining the master and sensor ends
`timescale 1ns/1ps
module air_quality_readout_ports_tb_top;
  import aqr_pkg::*;
  // short counts keep the run-in at 18000 cycles
  localparam int SEC_T = 20;
  localparam int PWM_T = 40;
  localparam int BAUD_T = 8;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic link_reset = 1'b1;
  logic rd_req = 1'b0;
  logic [15:0] meas_ppm = 16'h0000;
  logic [RES_W-1:0] meas_res = 24'h000000;
  logic meas_valid = 1'b0;
  logic nv_burned = 1'b1;
  logic nv_set_burned, burn_active, pwm_out, uart_tx;
  logic busy, result_valid, addr_nack;
  logic [15:0] result;
  logic wrote_nv = 1'b0;
  int num_errors = 0;
  int cmp_count = 0;
  int ppm0, res0;
  aqr_link_if link_bus();
  aqr_sensor_end #(.SEC_CYC(SEC_T), .PWM_CYC(PWM_T), .BAUD_CYC(BAUD_T))
    i_aqr_sensor_end (.clk(clk), .reset(reset), .link_clk(link_clk),
    .link_reset(link_reset), .meas_ppm(meas_ppm), .meas_res(meas_res),
    .meas_valid(meas_valid), .nv_burned(nv_burned),
    .nv_set_burned(nv_set_burned), .burn_active(burn_active),
    .pwm_out(pwm_out), .uart_tx(uart_tx), .link(link_bus));
  aqr_master_end i_aqr_master_end (.clk(clk), .reset(reset),
    .rd_req(rd_req), .busy(busy), .result(result),
    .result_valid(result_valid), .addr_nack(addr_nack), .link(link_bus));
  aqr_link_checker i_aqr_link_checker (.clk(clk), .reset(reset),
    .link_clk(link_clk), .link_reset(link_reset),
    .h_scl_o(link_bus.h_scl_o), .h_scl_oe(link_bus.h_scl_oe),
    .h_sda_o(link_bus.h_sda_o), .h_sda_oe(link_bus.h_sda_oe),
    .d_sda_o(link_bus.d_sda_o), .d_sda_oe(link_bus.d_sda_oe),
    .scl(link_bus.scl), .sda(link_bus.sda));
  initial forever #2 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge clk) if (nv_set_burned === 1'b1) wrote_nv <= 1'b1;
  task automatic fail(string msg);
    num_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic check_word(logic [15:0] got, logic [15:0] exp, string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask
  task automatic check_byte(logic [7:0] got, logic [7:0] exp, string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask
  task automatic check_bit(logic got, logic exp, string m);
    cmp_count++;
    if (got !== exp) fail(m);
  endtask
  task automatic check_count(int got, int exp, string m);
    cmp_count++;
    if (got != exp) fail(m);
  endtask
  function automatic int exp_duty(int p);
    if (p <= PPM_LO) return 0;
    if (p >= PPM_HI) return PWM_T;
    return (p - PPM_LO) * PWM_T / (PPM_HI - PPM_LO);
  endfunction
  function automatic logic [7:0] digit(int v, int pos);
    return CH_0 + 8'((v / (10 ** pos)) % 10);
  endfunction
  task automatic expect_byte(logic [7:0] exp);
    logic [7:0] b;
    int n;
    n = 0;
    while (uart_tx !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    repeat (BAUD_T / 2) @(negedge clk);
    check_bit(uart_tx, 1'b0, "serial start bit");
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_T) @(negedge clk);
      b[i] = uart_tx;
    end
    repeat (BAUD_T) @(negedge clk);
    check_bit(uart_tx, 1'b1, "serial stop bit");
    check_byte(b, exp, "serial character");
  endtask
  task automatic pwm_duty(output int hi);
    hi = 0;
    repeat (PWM_T) begin
      @(negedge clk);
      if (pwm_out === 1'b1) hi++;
    end
  endtask
  task automatic set_meas(int p);
    meas_ppm = 16'(p);
    meas_res = 24'(res0);
    meas_valid = 1'b1;
    @(negedge clk);
    meas_valid = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    // one i2c frame is about 72600 cycles and dominates the run
    repeat (95000) @(posedge clk);
    fail("watchdog expired");
    tally_and_finish;
  end
  initial begin
    int hi, w;
    int tbl[7];
    void'($urandom(19));
    ppm0 = $urandom_range(1999, 351);
    res0 = $urandom_range(16777215, 0);
    tbl = '{300, 350, 2000, 2500, 1175, 351, 0};
    tbl[6] = $urandom_range(2999, 0);
    repeat (20) @(negedge clk);
    reset = 1'b0;
    link_reset = 1'b0;
    set_meas(ppm0);
    fork
      begin
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
        @(negedge clk);
        check_bit(busy, 1'b1, "busy after request");
        w = 0;
        while (result_valid !== 1'b1 && w < 90000) begin
          @(negedge clk);
          w++;
        end
        check_word(result, 16'(ppm0), "i2c result");
        check_bit(addr_nack, 1'b0, "address refused");
        $display("test i2c read done");
      end
      begin
        for (int l = 0; l < 7; l++) begin
          expect_byte(CH_H);
          expect_byte(CH_0 + 8'(l));
          expect_byte(CH_CR);
          expect_byte(CH_LF);
        end
        for (int k = 4; k >= 0; k--) expect_byte(digit(350, k));
        expect_byte(CH_TAB);
        for (int k = 7; k >= 0; k--) expect_byte(digit(res0, k));
        expect_byte(CH_CR);
        expect_byte(CH_LF);
        $display("test serial text done");
      end
      begin
        repeat (100) @(negedge clk);
        pwm_duty(hi);
        check_count(hi, PWM_T / 2, "run-in duty");
        repeat (17760) @(negedge clk);
        check_bit(burn_active, 1'b1, "run-in ended early");
        repeat (200) @(negedge clk);
        check_bit(burn_active, 1'b0, "run-in ended late");
        repeat (2 * PWM_T + 2) @(negedge clk);
        pwm_duty(hi);
        check_count(hi, exp_duty(ppm0), "measured duty");
        $display("test run-in done");
      end
    join
    // the i2c read latched its value, so the ppm may now move
    for (int i = 0; i < 7; i++) begin
      set_meas(tbl[i]);
      repeat (2 * PWM_T + 2) @(negedge clk);
      pwm_duty(hi);
      check_count(hi, exp_duty(tbl[i]), "pwm duty");
    end
    check_bit(wrote_nv, 1'b0, "storage written again");
    $display("test pwm table done");
    tally_and_finish;
  end
endmodule
